// *** rtl/dsp_mac_datapath.sv ***
// MAC datapath: multiplier, 40-bit adder/subtracter, two accumulators,
// saturation, overflow flags and arithmetic trap request.
// Assumes the sequencer drives all inputs from the core clock domain.

module dsp_mac_datapath
  import dsp_mac_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_op_valid,
  input wire op_e i_op_code,
  input wire logic i_acc_sel,
  input wire logic [OPND_W-1:0] i_x_data,
  input wire logic [OPND_W-1:0] i_y_data,
  input wire logic [ACC_W-1:0] i_shift_data,
  input wire logic i_mul_byte,
  input wire logic i_frac_mode,
  input wire logic i_unsigned_select,
  input wire logic i_round_mode_select,
  input wire logic i_acc_a_sat_enable,
  input wire logic i_acc_b_sat_enable,
  input wire logic i_write_sat_enable,
  input wire logic i_sat_mode_select,
  input wire logic i_acc_a_trap_enable,
  input wire logic i_acc_b_trap_enable,
  input wire logic i_catastrophic_trap_enable,
  input wire logic i_acc_a_sat_clear,
  input wire logic i_acc_b_sat_clear,
  output logic [ACC_W-1:0] o_accumulator_a,
  output logic [ACC_W-1:0] o_accumulator_b,
  output logic o_acc_a_guard_ovf,
  output logic o_acc_b_guard_ovf,
  output logic o_acc_a_sat_flag,
  output logic o_acc_b_sat_flag,
  output logic o_any_guard_ovf,
  output logic o_any_sat_flag,
  output logic o_trap_req,
  output logic [2*OPND_W-1:0] o_mul_result,
  output logic o_mul_valid,
  output logic [CFG_W-1:0] o_core_config_reg
);

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rstn);

  typedef struct packed {
    logic [ACC_W-1:0] acc_a;
    logic [ACC_W-1:0] acc_b;
    logic guard_a;
    logic guard_b;
    logic sat_a;
    logic sat_b;
    logic any_guard;
    logic any_sat;
    logic trap;
    logic [2*OPND_W-1:0] mul_result;
    logic mul_valid;
    logic [CFG_W-1:0] cfg;
  } state_s;

  state_s st_reg;
  state_s st_next;

  // True when bits ACC_W-1 down to lo are all copies of one another
  function automatic logic bits_agree(input logic [ACC_W-1:0] v, input int lo);
    logic agree;
    agree = 1'b1;
    for (int i = lo; i < ACC_W - 1; i++) begin
      if (v[i] != v[ACC_W-1]) begin
        agree = 1'b0;
      end
    end
    return agree;
  endfunction : bits_agree

  // ****************************************************************
  // Multiplier
  // ****************************************************************
  mul_if mul_bus ();

  assign mul_bus.x = i_x_data;
  assign mul_bus.y = i_y_data;
  assign mul_bus.unsigned_sel = i_unsigned_select;
  assign mul_bus.frac_sel = i_frac_mode && (i_op_code != OP_MUL_INT);
  assign mul_bus.byte_sel = i_mul_byte && (i_op_code == OP_MUL_INT);

  dsp_mul_scaler u_mul (
    .m(mul_bus)
  );

  logic [ACC_W-1:0] prod_ext;
  assign prod_ext = {{(ACC_W-PROD_W){mul_bus.product[PROD_W-1]}}, mul_bus.product};

  // ****************************************************************
  // Adder operand selection
  // ****************************************************************
  logic [ACC_W-1:0] acc_tgt;
  logic [ACC_W-1:0] acc_oth;
  logic [ACC_W-1:0] add_a;
  logic [ACC_W-1:0] operand;
  logic zero_in;
  logic subtract;
  logic acc_write;

  assign acc_tgt = (i_acc_sel == ACC_SEL_B) ? st_reg.acc_b : st_reg.acc_a;
  assign acc_oth = (i_acc_sel == ACC_SEL_B) ? st_reg.acc_a : st_reg.acc_b;

  always_comb begin
    zero_in = 1'b0;
    subtract = 1'b0;
    operand = prod_ext;
    acc_write = i_op_valid;
    case (i_op_code)
      OP_MAC: begin
      end
      OP_MSC: begin
        subtract = 1'b1;
      end
      OP_MPY: begin
        zero_in = 1'b1;
      end
      OP_MPY_N: begin
        zero_in = 1'b1;
        subtract = 1'b1;
      end
      OP_CLR: begin
        zero_in = 1'b1;
        operand = ACC_RESET;
      end
      OP_ADD_ACC: begin
        operand = acc_oth;
      end
      OP_SUB_ACC: begin
        operand = acc_oth;
        subtract = 1'b1;
      end
      OP_NEG: begin
        zero_in = 1'b1;
        operand = acc_tgt;
        subtract = 1'b1;
      end
      OP_ADD_DATA: begin
        operand = i_shift_data;
      end
      OP_LAC: begin
        zero_in = 1'b1;
        operand = i_shift_data;
      end
      default: begin
        acc_write = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // 40-bit adder/subtracter
  // ****************************************************************
  // Subtract is a + ~b + 1: the carry input follows subtract and is low for adds.
  logic [ACC_W-1:0] add_b;
  logic [ACC_W-1:0] add_sum;
  logic ovf39;
  logic ovf31;
  logic guard_hit;

  assign add_a = zero_in ? ACC_RESET : acc_tgt;
  assign add_b = subtract ? ~operand : operand;
  assign add_sum = add_a + add_b + {{(ACC_W-1){1'b0}}, subtract};
  assign ovf39 = (add_a[ACC_W-1] == add_b[ACC_W-1]) && (add_sum[ACC_W-1] != add_a[ACC_W-1]);
  assign ovf31 = !bits_agree(add_sum, Q31_TOP);
  assign guard_hit = !bits_agree(add_sum, GUARD_LO);

  // ****************************************************************
  // Saturation
  // ****************************************************************
  logic sat_en;
  logic sat_hit;
  logic cat_event;
  logic guard_new;
  logic [ACC_W-1:0] acc_result;

  assign sat_en = (i_acc_sel == ACC_SEL_B) ? i_acc_b_sat_enable : i_acc_a_sat_enable;

  always_comb begin
    acc_result = add_sum;
    sat_hit = 1'b0;
    cat_event = 1'b0;
    if (sat_en) begin
      if (ovf39) begin
        // True sign is the inverse of the wrapped bit 39
        sat_hit = 1'b1;
        if (i_sat_mode_select == SAT_MODE_BIT39) begin
          acc_result = add_sum[ACC_W-1] ? SAT39_POS : SAT39_NEG;
        end else begin
          acc_result = add_sum[ACC_W-1] ? SAT31_POS : SAT31_NEG;
        end
      end else if ((i_sat_mode_select != SAT_MODE_BIT39) && ovf31) begin
        sat_hit = 1'b1;
        acc_result = add_sum[ACC_W-1] ? SAT31_NEG : SAT31_POS;
      end
    end else if (ovf39) begin
      sat_hit = 1'b1;
      cat_event = 1'b1;
    end
  end

  // Guard bits are unused in 1.31 saturation mode
  assign guard_new = guard_hit && !(sat_en && (i_sat_mode_select != SAT_MODE_BIT39));

  // ****************************************************************
  // State update
  // ****************************************************************
  always_comb begin
    st_next = st_reg;
    st_next.mul_valid = 1'b0;
    st_next.cfg = '0;
    st_next.cfg[CFG_FRAC_BIT] = i_frac_mode;
    st_next.cfg[CFG_RND_BIT] = i_round_mode_select;
    st_next.cfg[CFG_ACCSEL_BIT] = i_sat_mode_select;
    st_next.cfg[CFG_WRITE_SAT_ENABLE_BIT] = i_write_sat_enable;
    st_next.cfg[CFG_ACC_B_SAT_ENABLE_BIT] = i_acc_b_sat_enable;
    st_next.cfg[CFG_ACC_A_SAT_ENABLE_BIT] = i_acc_a_sat_enable;
    st_next.cfg[CFG_US_BIT] = i_unsigned_select;
    // A hardware set in the clear cycle wins over the software clear
    if (i_acc_a_sat_clear) begin
      st_next.sat_a = 1'b0;
    end
    if (i_acc_b_sat_clear) begin
      st_next.sat_b = 1'b0;
    end
    if (i_op_valid && (i_op_code == OP_MUL_INT)) begin
      st_next.mul_valid = 1'b1;
      if (i_mul_byte) begin
        st_next.mul_result = {{OPND_W{1'b0}}, mul_bus.product[OPND_W-1:0]};
      end else begin
        st_next.mul_result = mul_bus.product[2*OPND_W-1:0];
      end
    end
    if (acc_write) begin
      if (i_acc_sel == ACC_SEL_B) begin
        st_next.acc_b = acc_result;
        st_next.guard_b = guard_new;
        st_next.sat_b = st_next.sat_b | sat_hit;
      end else begin
        st_next.acc_a = acc_result;
        st_next.guard_a = guard_new;
        st_next.sat_a = st_next.sat_a | sat_hit;
      end
    end
    st_next.any_guard = st_next.guard_a | st_next.guard_b;
    st_next.any_sat = st_next.sat_a | st_next.sat_b;
    st_next.trap = (st_next.guard_a & i_acc_a_trap_enable) | (st_next.guard_b & i_acc_b_trap_enable) |
                   (acc_write & cat_event & i_catastrophic_trap_enable);
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_accumulator_a = st_reg.acc_a;
  assign o_accumulator_b = st_reg.acc_b;
  assign o_acc_a_guard_ovf = st_reg.guard_a;
  assign o_acc_b_guard_ovf = st_reg.guard_b;
  assign o_acc_a_sat_flag = st_reg.sat_a;
  assign o_acc_b_sat_flag = st_reg.sat_b;
  assign o_any_guard_ovf = st_reg.any_guard;
  assign o_any_sat_flag = st_reg.any_sat;
  assign o_trap_req = st_reg.trap;
  assign o_mul_result = st_reg.mul_result;
  assign o_mul_valid = st_reg.mul_valid;
  assign o_core_config_reg = st_reg.cfg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence seq_issue_a;
    i_op_valid && acc_write && (i_acc_sel != ACC_SEL_B);
  endsequence

  sequence seq_mpy_a;
    seq_issue_a ##0 (i_op_code == OP_MPY) && !ovf39 && !(i_acc_a_sat_enable && ovf31);
  endsequence

  a_mpy_sign_ext: assert property (seq_mpy_a |=>
    o_accumulator_a == {{(ACC_W-PROD_W){$past(mul_bus.product[PROD_W-1])}}, $past(mul_bus.product)})
    else $error("product not sign-extended into accumulator A");

  // With 1.31 saturation on, the +1.0 product is clipped to the largest 1.31 value
  a_frac_minus_one: assert property (seq_issue_a ##0 (i_op_code == OP_MPY) && i_frac_mode &&
    !i_unsigned_select && (i_x_data == 16'h8000) && (i_y_data == 16'h8000) |=>
    o_accumulator_a == (($past(i_acc_a_sat_enable) && ($past(i_sat_mode_select) != SAT_MODE_BIT39)) ?
    SAT31_POS : 40'h0080000000))
    else $error("fractional -1 times -1 not 1.31 one");

  a_int_mul_out: assert property (i_op_valid && (i_op_code == OP_MUL_INT) && !i_mul_byte &&
    !i_unsigned_select |=> o_mul_valid &&
    ($signed(o_mul_result) == $signed($past(i_x_data)) * $signed($past(i_y_data))))
    else $error("integer word multiply result wrong");

  a_guard_rewrite: assert property (seq_issue_a ##0 !i_acc_a_sat_enable |=>
    o_acc_a_guard_ovf == !bits_agree($past(add_sum), GUARD_LO))
    else $error("guard flag A not rewritten from result");

  a_bit31_no_guard: assert property (seq_issue_a ##0 i_acc_a_sat_enable &&
    (i_sat_mode_select != SAT_MODE_BIT39) |=> !o_acc_a_guard_ovf &&
    (o_accumulator_a[ACC_W-1:Q31_TOP] == '0 || o_accumulator_a[ACC_W-1:Q31_TOP] == '1 ||
    o_accumulator_a == SAT31_NEG))
    else $error("bit 31 mode left guard flag or out-of-range value");

  a_sat39_extreme: assert property (seq_issue_a ##0 i_acc_a_sat_enable && ovf39 &&
    (i_sat_mode_select == SAT_MODE_BIT39) |=> o_acc_a_sat_flag &&
    (o_accumulator_a == SAT39_POS || o_accumulator_a == SAT39_NEG))
    else $error("bit 39 saturation value or flag wrong");

  a_sat_sticky: assert property (o_acc_a_sat_flag && !i_acc_a_sat_clear |=> o_acc_a_sat_flag)
    else $error("saturation flag A dropped without clear");

  a_wrap_trap: assert property (seq_issue_a ##0 !i_acc_a_sat_enable && ovf39 &&
    i_catastrophic_trap_enable |=> o_acc_a_sat_flag && o_trap_req &&
    (o_accumulator_a == $past(add_sum)))
    else $error("catastrophic overflow did not wrap and trap");

  a_guard_trap: assert property (o_acc_b_guard_ovf && $past(i_acc_b_trap_enable) |-> o_trap_req)
    else $error("guard overflow B with trap enable gave no trap");

  a_combined_bits: assert property (o_any_sat_flag == (o_acc_a_sat_flag | o_acc_b_sat_flag) &&
    o_any_guard_ovf == (o_acc_a_guard_ovf | o_acc_b_guard_ovf))
    else $error("combined status bits disagree with flags");

  a_neg_acc: assert property (seq_issue_a ##0 (i_op_code == OP_NEG) && !ovf39 && !i_acc_a_sat_enable |=>
    o_accumulator_a == ACC_RESET - $past(o_accumulator_a))
    else $error("negate of accumulator A wrong");

endmodule : dsp_mac_datapath

// *** rtl/dsp_mac_pkg.sv ***
// Constants, operation codes and configuration layout of the MAC datapath.
// Assumes a single core clock; shared by the datapath and its multiplier.
package dsp_mac_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int ACC_W = 40;
  localparam int OPND_W = 16;
  localparam int BYTE_W = 8;
  localparam int MUL_IN_W = 17;
  localparam int PROD_W = 33;
  localparam int CFG_W = 16;

  // ****************************************************************
  // Overflow detection points
  // ****************************************************************
  localparam int GUARD_LO = 32;
  localparam int Q31_TOP = 31;

  // ****************************************************************
  // Saturation values
  // ****************************************************************
  localparam logic [ACC_W-1:0] SAT39_POS = 40'h7fffffffff;
  localparam logic [ACC_W-1:0] SAT39_NEG = 40'h8000000000;
  localparam logic [ACC_W-1:0] SAT31_POS = 40'h007fffffff;
  localparam logic [ACC_W-1:0] SAT31_NEG = 40'h0080000000;
  localparam logic [ACC_W-1:0] ACC_RESET = 40'h0000000000;

  // ****************************************************************
  // Core configuration word layout
  // ****************************************************************
  localparam int CFG_FRAC_BIT = 0;
  localparam int CFG_RND_BIT = 1;
  localparam int CFG_ACCSEL_BIT = 4;
  localparam int CFG_WRITE_SAT_ENABLE_BIT = 5;
  localparam int CFG_ACC_B_SAT_ENABLE_BIT = 6;
  localparam int CFG_ACC_A_SAT_ENABLE_BIT = 7;
  localparam int CFG_US_BIT = 12;

  localparam logic SAT_MODE_BIT39 = 1'b1;
  localparam logic ACC_SEL_B = 1'b1;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_MAC = 4'h1,
    OP_MSC = 4'h2,
    OP_MPY = 4'h3,
    OP_MPY_N = 4'h4,
    OP_CLR = 4'h5,
    OP_ADD_ACC = 4'h6,
    OP_SUB_ACC = 4'h7,
    OP_NEG = 4'h8,
    OP_ADD_DATA = 4'h9,
    OP_LAC = 4'ha,
    OP_MUL_INT = 4'hb
  } op_e;

endpackage : dsp_mac_pkg

// *** rtl/mul_if.sv ***
// Operand and product bundle between the datapath and its multiplier.
// Purely combinational; no clock travels in it.
interface mul_if;
  import dsp_mac_pkg::*;
  logic [OPND_W-1:0] x;
  logic [OPND_W-1:0] y;
  logic unsigned_sel;
  logic frac_sel;
  logic byte_sel;
  logic [PROD_W-1:0] product;
  modport req (output x, output y, output unsigned_sel, output frac_sel, output byte_sel, input product);
  modport mul (input x, input y, input unsigned_sel, input frac_sel, input byte_sel, output product);
endinterface : mul_if

// *** rtl/dsp_mul_scaler.sv ***
// 17x17 multiplier with fractional/integer output scaler.
// Combinational; the caller registers the result in the same cycle.
module dsp_mul_scaler
  import dsp_mac_pkg::*;
(
  mul_if.mul m
);

  logic signed [MUL_IN_W-1:0] x_ext;
  logic signed [MUL_IN_W-1:0] y_ext;
  logic signed [2*MUL_IN_W-1:0] prod_full;

  // ****************************************************************
  // Operand widening into the 17th bit
  // ****************************************************************
  always_comb begin
    if (m.byte_sel) begin
      if (m.unsigned_sel) begin
        x_ext = {{(MUL_IN_W-BYTE_W){1'b0}}, m.x[BYTE_W-1:0]};
        y_ext = {{(MUL_IN_W-BYTE_W){1'b0}}, m.y[BYTE_W-1:0]};
      end else begin
        x_ext = {{(MUL_IN_W-BYTE_W){m.x[BYTE_W-1]}}, m.x[BYTE_W-1:0]};
        y_ext = {{(MUL_IN_W-BYTE_W){m.y[BYTE_W-1]}}, m.y[BYTE_W-1:0]};
      end
    end else if (m.unsigned_sel) begin
      x_ext = {1'b0, m.x};
      y_ext = {1'b0, m.y};
    end else begin
      x_ext = {m.x[OPND_W-1], m.x};
      y_ext = {m.y[OPND_W-1], m.y};
    end
  end

  assign prod_full = x_ext * y_ext;

  // ****************************************************************
  // Scaler
  // ****************************************************************
  // Fractional Q15 x Q15 gives Q30; one left shift lines it up as 1.31.
  // Byte multiplies are never scaled so the 16-bit result stays integer.
  always_comb begin
    if (m.frac_sel && !m.byte_sel) begin
      m.product = {prod_full[PROD_W-2:0], 1'b0};
    end else begin
      m.product = prod_full[PROD_W-1:0];
    end
  end

endmodule : dsp_mul_scaler

// *** bench/seq_model.sv ***
// Sequencer model: issues one datapath operation at a time and drives the config bits.
// Assumes the core clock from the bench; after the blocking time-zero defaults, every drive is non-blocking on the rising edge.
module seq_model
  import dsp_mac_pkg::*;
(
  input wire logic i_core_clk,
  output logic o_op_valid,
  output op_e o_op_code,
  output logic o_acc_sel,
  output logic [OPND_W-1:0] o_x_data,
  output logic [OPND_W-1:0] o_y_data,
  output logic [ACC_W-1:0] o_shift_data,
  output logic o_mul_byte,
  output logic [9:0] o_cfg,
  output logic o_sat_clear_a,
  output logic o_sat_clear_b
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    o_op_valid = 1'b0;
    o_op_code = OP_NONE;
    o_acc_sel = 1'b0;
    o_x_data = 16'h0000;
    o_y_data = 16'h0000;
    o_shift_data = 40'h0000000000;
    o_mul_byte = 1'b0;
    o_cfg = 10'h000;
    o_sat_clear_a = 1'b0;
    o_sat_clear_b = 1'b0;
  end

  // ****************************************************************
  // Access tasks
  // ****************************************************************
  task automatic issue(input op_e op, input logic sel, input logic [OPND_W-1:0] x, input logic [OPND_W-1:0] y,
      input logic [ACC_W-1:0] sh, input logic byt);
    @(posedge i_core_clk);
    o_op_valid <= 1'b1;
    o_op_code <= op;
    o_acc_sel <= sel;
    o_x_data <= x;
    o_y_data <= y;
    o_shift_data <= sh;
    o_mul_byte <= byt;
    @(posedge i_core_clk);
    // Operands scrambled once released, so stale values cannot pass for held ones
    o_op_valid <= 1'b0;
    o_x_data <= ~x;
    o_y_data <= ~y;
    o_shift_data <= ~sh;
    #1;
  endtask : issue

  task automatic idle();
    @(posedge i_core_clk);
    #1;
  endtask : idle

  task automatic set_cfg(input logic [9:0] c);
    @(posedge i_core_clk);
    o_cfg <= c;
    @(posedge i_core_clk);
    #1;
  endtask : set_cfg

  task automatic clear(input logic a, input logic b);
    @(posedge i_core_clk);
    o_sat_clear_a <= a;
    o_sat_clear_b <= b;
    @(posedge i_core_clk);
    o_sat_clear_a <= 1'b0;
    o_sat_clear_b <= 1'b0;
    #1;
  endtask : clear
endmodule : seq_model

// *** bench/tb_top.sv ***
// Self-checking bench for the MAC datapath, driven through the sequencer model.
// Assumes one 100 MHz core clock and a one-cycle registered answer.
module tb_top
  import dsp_mac_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic i_core_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic op_valid, acc_sel, mul_byte, clr_a, clr_b;
  op_e op_code;
  logic [OPND_W-1:0] x_data, y_data;
  logic [ACC_W-1:0] shift_data, acc_a, acc_b;
  logic [9:0] cfg;
  logic frac_mode, unsigned_select, round_mode_select, acc_a_sat_enable, acc_b_sat_enable, write_sat_enable;
  logic sat_mode_select, acc_a_trap_enable, acc_b_trap_enable, catastrophic_trap_enable;
  logic acc_a_guard_ovf, acc_b_guard_ovf, acc_a_sat_flag, acc_b_sat_flag, any_guard_ovf, any_sat_flag;
  logic trap_req, mul_valid;
  logic [2*OPND_W-1:0] mul_result;
  logic [CFG_W-1:0] core_config_reg;
  logic [7:0] flg;
  int err_total = 0;
  int n_tests = 0;

  assign flg = {acc_a_guard_ovf, acc_b_guard_ovf, acc_a_sat_flag, acc_b_sat_flag, any_guard_ovf, any_sat_flag,
      trap_req, mul_valid};
  assign {frac_mode, unsigned_select, round_mode_select, acc_a_sat_enable, acc_b_sat_enable, write_sat_enable,
      sat_mode_select, acc_a_trap_enable, acc_b_trap_enable, catastrophic_trap_enable} = cfg;
  always #5 i_core_clk = ~i_core_clk;

  seq_model seq_model_i (.i_core_clk(i_core_clk), .o_op_valid(op_valid), .o_op_code(op_code), .o_acc_sel(acc_sel),
      .o_x_data(x_data), .o_y_data(y_data), .o_shift_data(shift_data), .o_mul_byte(mul_byte), .o_cfg(cfg),
      .o_sat_clear_a(clr_a), .o_sat_clear_b(clr_b));

  dsp_mac_datapath dsp_mac_datapath_i (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_op_valid(op_valid),
      .i_op_code(op_code), .i_acc_sel(acc_sel), .i_x_data(x_data), .i_y_data(y_data), .i_shift_data(shift_data),
      .i_mul_byte(mul_byte), .i_frac_mode(frac_mode), .i_unsigned_select(unsigned_select),
      .i_round_mode_select(round_mode_select), .i_acc_a_sat_enable(acc_a_sat_enable),
      .i_acc_b_sat_enable(acc_b_sat_enable), .i_write_sat_enable(write_sat_enable),
      .i_sat_mode_select(sat_mode_select), .i_acc_a_trap_enable(acc_a_trap_enable),
      .i_acc_b_trap_enable(acc_b_trap_enable), .i_catastrophic_trap_enable(catastrophic_trap_enable),
      .i_acc_a_sat_clear(clr_a), .i_acc_b_sat_clear(clr_b),
      .o_accumulator_a(acc_a), .o_accumulator_b(acc_b), .o_acc_a_guard_ovf(acc_a_guard_ovf),
      .o_acc_b_guard_ovf(acc_b_guard_ovf), .o_acc_a_sat_flag(acc_a_sat_flag), .o_acc_b_sat_flag(acc_b_sat_flag),
      .o_any_guard_ovf(any_guard_ovf), .o_any_sat_flag(any_sat_flag), .o_trap_req(trap_req),
      .o_mul_result(mul_result), .o_mul_valid(mul_valid), .o_core_config_reg(core_config_reg));

  // ****************************************************************
  // Checking tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Flags are {guard a, guard b, sat a, sat b, any guard, any sat, trap, mul valid}
  task automatic run(input op_e op, input logic sel, input logic [OPND_W-1:0] x, input logic [OPND_W-1:0] y,
      input logic [ACC_W-1:0] sh, input string nm, input logic [47:0] exp);
    seq_model_i.issue(op, sel, x, y, sh, 1'b0);
    chk(nm, {sel ? acc_b : acc_a, flg}, exp);
  endtask : run

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    @(posedge i_core_clk);
    #1;
    chk("reset", {acc_a, flg}, 48'h0);
    @(posedge i_core_clk);
    i_rstn <= 1'b1;
    seq_model_i.set_cfg(10'b1000000000);
    run(OP_MPY, 1'b0, 16'h4000, 16'h4000, 40'h0, "mpy_frac", {40'h0020000000, 8'h00});
    run(OP_MPY, 1'b1, 16'h8000, 16'h8000, 40'h0, "mpy_q15_min", {40'h0080000000, 8'h00});
    seq_model_i.set_cfg(10'b0000000000);
    run(OP_MPY, 1'b0, 16'hffff, 16'h0002, 40'h0, "mpy_signed", {40'hfffffffffe, 8'h00});
    seq_model_i.issue(OP_MUL_INT, 1'b0, 16'hfffe, 16'h0003, 40'h0, 1'b0);
    chk("mul_signed", {8'h00, mul_result, flg}, {40'h00fffffffa, 8'h01});
    seq_model_i.set_cfg(10'b0100000000);
    run(OP_MPY, 1'b0, 16'hffff, 16'hffff, 40'h0, "mpy_unsigned", {40'h00fffe0001, 8'h00});
    seq_model_i.issue(OP_MUL_INT, 1'b0, 16'hffff, 16'hffff, 40'h0, 1'b0);
    chk("mul_word", {8'h00, mul_result, flg}, {40'h00fffe0001, 8'h01});
    seq_model_i.issue(OP_MUL_INT, 1'b0, 16'h12ff, 16'h34ff, 40'h0, 1'b1);
    chk("mul_byte", {8'h00, mul_result, flg}, {40'h000000fe01, 8'h01});
    seq_model_i.idle();
    chk("mul_valid_end", {40'h0, flg}, 48'h0);
    seq_model_i.set_cfg(10'b0000000000);
    run(OP_LAC, 1'b0, 16'h0, 16'h0, 40'h5, "lac_a", {40'h5, 8'h00});
    run(OP_LAC, 1'b1, 16'h0, 16'h0, 40'h3, "lac_b", {40'h3, 8'h00});
    run(OP_ADD_ACC, 1'b0, 16'h0, 16'h0, 40'h0, "add_acc", {40'h8, 8'h00});
    run(OP_SUB_ACC, 1'b0, 16'h0, 16'h0, 40'h0, "sub_acc", {40'h5, 8'h00});
    run(OP_NEG, 1'b0, 16'h0, 16'h0, 40'h0, "neg", {40'hfffffffffb, 8'h00});
    run(OP_CLR, 1'b0, 16'h0, 16'h0, 40'h0, "clr", {40'h0, 8'h00});
    run(OP_MAC, 1'b0, 16'h0003, 16'h0004, 40'h0, "mac", {40'hc, 8'h00});
    run(OP_MSC, 1'b0, 16'h0002, 16'h0002, 40'h0, "msc", {40'h8, 8'h00});
    // Bit 39 saturation on B, guard trap enabled on B
    seq_model_i.set_cfg(10'b0000101010);
    run(OP_LAC, 1'b1, 16'h0, 16'h0, 40'h7f00000000, "guard_b", {40'h7f00000000, 8'b01001010});
    run(OP_ADD_DATA, 1'b1, 16'h0, 16'h0, 40'h7f00000000, "sat39_b", {SAT39_POS, 8'b01011110});
    seq_model_i.idle();
    chk("sat_sticky", {acc_b, flg}, {SAT39_POS, 8'b01011110});
    seq_model_i.clear(1'b0, 1'b1);
    chk("sat_clear", {acc_b, flg}, {SAT39_POS, 8'b01001010});
    run(OP_LAC, 1'b1, 16'h0, 16'h0, 40'h1, "guard_rewrite", {40'h1, 8'h00});
    // Bit 39 saturation on A toward the negative end, guard trap enabled on A
    seq_model_i.set_cfg(10'b0001001100);
    run(OP_LAC, 1'b0, 16'h0, 16'h0, 40'h8100000000, "guard_a", {40'h8100000000, 8'b10001010});
    run(OP_ADD_DATA, 1'b0, 16'h0, 16'h0, 40'h8100000000, "sat39_a", {SAT39_NEG, 8'b10101110});
    // Bit 31 saturation on A
    seq_model_i.set_cfg(10'b1001000000);
    run(OP_MPY, 1'b0, 16'h8000, 16'h8000, 40'h0, "sat31_a", {SAT31_POS, 8'b00100100});
    seq_model_i.clear(1'b1, 1'b0);
    chk("sat_clear_a", {acc_a, flg}, {SAT31_POS, 8'h00});
    // Saturation off, catastrophic trap enabled
    seq_model_i.set_cfg(10'b0000000001);
    run(OP_LAC, 1'b0, 16'h0, 16'h0, SAT39_POS, "lac_top", {SAT39_POS, 8'b10001000});
    run(OP_ADD_DATA, 1'b0, 16'h0, 16'h0, 40'h1, "wrap", {SAT39_NEG, 8'b10101110});
    seq_model_i.idle();
    chk("trap_pulse_end", {acc_a, flg}, {SAT39_NEG, 8'b10101100});
    seq_model_i.set_cfg(10'b1010111000);
    chk("config_a", {32'h0, core_config_reg}, 48'h0073);
    seq_model_i.set_cfg(10'b1101000000);
    chk("config_b", {32'h0, core_config_reg}, 48'h1081);
    tally_and_finish();
  end

  // A hung run is cut short well after the roughly 75 cycles the sequence needs
  initial begin
    #20000;
    err_total++;
    tally_and_finish();
  end
endmodule : tb_top
